/* File: logic/pac_port.sv */
// parallel control port: pin decode, auto-zero sequencer, status pins, avalon slave
// assumes pins and analogue comparator/adc inputs synchronous to ref_clk
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`default_nettype none
// Notes on behaviour
// - pins live right after reset, no enable
// - power indication high while operating
// - overload high while signal over range
// - auto-zero ready low during offset acquisition
// - gain codes zero..five select six ranges
// - bandwidth lines one-hot or all low
// - polarity high inverts the output
// - auto-zero stores per-range offsets, subtracts them
// - auto-zero reset discards offsets
module pac_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // control pins and analogue side
  input wire pac_pkg::pac_pins_t pins,
  input wire logic sig_over,
  input wire logic [pac_pkg::ADC_W-1:0] adc_sample,
  // status pins and selections
  output pac_pkg::pac_stat_t stat,
  output logic [5:0] gain_sel,
  output logic [3:0] bw_sel,
  output logic invert,
  output logic signed [pac_pkg::ADC_W:0] sample_out,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);
  pac_pkg::pac_az_state_t state_reg, state_next;
  logic [pac_pkg::AZ_CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] az_idx_reg, az_idx_next, gain_idx_reg, gain_idx_next;
  logic [2:0] app_idx_reg, app_idx_next;
  logic [3:0] bw_reg, bw_next;
  logic [5:0] valid_reg, valid_next, gain_sel_reg, gain_sel_next;
  logic comp_reg, comp_next, ready_reg, ready_next, pwr_reg, ovl_reg, inv_reg;
  logic start_q_reg, rst_q_reg, bad_q_reg, bad_now;
  logic signed [pac_pkg::ADC_W:0] out_reg, out_next, diff;
  logic start_ev, rst_ev, done_ev, ofs_we;
  logic [pac_pkg::ADC_W-1:0] ofs_rdata;
  logic sw_start_reg, sw_start_next, sw_reset_reg, sw_reset_next;
  logic [pac_pkg::IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next, iev;
  logic wait_reg, wait_next, irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next, wmask, status_word;

  pac_ofs_mem u_ofs_mem (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .we(ofs_we),
    .waddr(az_idx_reg),
    .wdata(adc_sample),
    .raddr(app_idx_next),
    .rdata(ofs_rdata)
  );

  // core next-state logic
  always_comb begin
    start_ev = (pins.az_start & ~start_q_reg) | sw_start_reg;
    rst_ev = (pins.az_reset & ~rst_q_reg) | sw_reset_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    az_idx_next = az_idx_reg;
    valid_next = valid_reg;
    comp_next = comp_reg;
    ready_next = ready_reg;
    ofs_we = 1'b0;
    done_ev = 1'b0;
    gain_idx_next = gain_idx_reg;
    bw_next = bw_reg;
    if (pins.gain_code <= pac_pkg::GAIN_MAX_CODE) begin
      gain_idx_next = pins.gain_code;
    end
    case (pins.bw_code)
      3'b000: bw_next = pac_pkg::BW_10K;
      3'b001: bw_next = pac_pkg::BW_1K;
      3'b010: bw_next = pac_pkg::BW_100;
      3'b100: bw_next = pac_pkg::BW_10;
      default: bw_next = bw_reg;
    endcase
    bad_now = (pins.gain_code > pac_pkg::GAIN_MAX_CODE) | (bw_next == bw_reg &&
      pins.bw_code != 3'b000 && pins.bw_code != 3'b001 && pins.bw_code != 3'b010 &&
      pins.bw_code != 3'b100);
    case (state_reg)
      pac_pkg::AZ_IDLE: begin
        if (start_ev && !rst_ev) begin
          state_next = pac_pkg::AZ_SETTLE;
          cnt_next = '0;
          az_idx_next = 3'h0;
          valid_next = '0;
          comp_next = 1'b0;
          ready_next = 1'b0;
        end
      end
      pac_pkg::AZ_SETTLE: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == pac_pkg::AZ_CNT_W'(pac_pkg::AZ_SETTLE_CYC - 1)) begin
          state_next = pac_pkg::AZ_CAPT;
        end
      end
      pac_pkg::AZ_CAPT: begin
        ofs_we = 1'b1;
        valid_next[az_idx_reg] = ~sig_over;
        cnt_next = '0;
        if (az_idx_reg == 3'(pac_pkg::NUM_RANGES - 1)) begin
          state_next = pac_pkg::AZ_IDLE;
          comp_next = 1'b1;
          ready_next = 1'b1;
          done_ev = 1'b1;
        end else begin
          az_idx_next = az_idx_reg + 3'h1;
          state_next = pac_pkg::AZ_SETTLE;
        end
      end
      default: begin
        state_next = pac_pkg::AZ_IDLE;
        ready_next = 1'b1;
      end
    endcase
    if (rst_ev) begin
      state_next = pac_pkg::AZ_IDLE;
      ofs_we = 1'b0;
      done_ev = 1'b0;
      valid_next = '0;
      comp_next = 1'b0;
      ready_next = 1'b1;
    end
    app_idx_next = (state_next == pac_pkg::AZ_IDLE) ? gain_idx_next : az_idx_next;
    gain_sel_next = 6'h01 << app_idx_next;
    // subtract stored offset of applied range
    if (comp_reg && valid_reg[app_idx_reg]) begin
      diff = $signed({1'b0, adc_sample}) - $signed({1'b0, ofs_rdata});
    end else begin
      diff = $signed({1'b0, adc_sample});
    end
    out_next = pins.polarity ? -diff : diff;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= pac_pkg::AZ_IDLE;
      cnt_reg <= '0;
      az_idx_reg <= 3'h0;
      gain_idx_reg <= pac_pkg::GAIN_RST_IDX;
      app_idx_reg <= pac_pkg::GAIN_RST_IDX;
      gain_sel_reg <= 6'h01;
      bw_reg <= pac_pkg::BW_10K;
      valid_reg <= '0;
      comp_reg <= 1'b0;
      ready_reg <= 1'b1;
      pwr_reg <= 1'b0;
      ovl_reg <= 1'b0;
      inv_reg <= 1'b0;
      start_q_reg <= 1'b0;
      rst_q_reg <= 1'b0;
      bad_q_reg <= 1'b0;
      out_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      az_idx_reg <= az_idx_next;
      gain_idx_reg <= gain_idx_next;
      app_idx_reg <= app_idx_next;
      gain_sel_reg <= gain_sel_next;
      bw_reg <= bw_next;
      valid_reg <= valid_next;
      comp_reg <= comp_next;
      ready_reg <= ready_next;
      pwr_reg <= 1'b1;
      ovl_reg <= sig_over;
      inv_reg <= pins.polarity;
      start_q_reg <= pins.az_start;
      rst_q_reg <= pins.az_reset;
      bad_q_reg <= bad_now;
      out_reg <= out_next;
    end
  end

  // bus and interrupt next-state logic
  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    status_word = '0;
    status_word[pac_pkg::ST_GAIN_LSB +: 3] = gain_idx_reg;
    status_word[pac_pkg::ST_BW_LSB +: 4] = bw_reg;
    status_word[pac_pkg::ST_INV] = inv_reg;
    status_word[pac_pkg::ST_BUSY] = (state_reg != pac_pkg::AZ_IDLE);
    status_word[pac_pkg::ST_COMP] = comp_reg;
    status_word[pac_pkg::ST_VALID_LSB +: 6] = valid_reg;
    iev = '0;
    iev[pac_pkg::IRQ_AZ_DONE] = done_ev;
    iev[pac_pkg::IRQ_OVERLOAD] = sig_over & ~ovl_reg;
    iev[pac_pkg::IRQ_BAD_CODE] = bad_now & ~bad_q_reg;
    ist_next = ist_reg;
    imask_next = imask_reg;
    sw_start_next = 1'b0;
    sw_reset_next = 1'b0;
    rdata_next = rdata_reg;
    wait_next = 1'b1;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = '0;
      case (avs_address)
        pac_pkg::REG_STATUS: rdata_next = status_word;
        pac_pkg::REG_IRQ_STAT: rdata_next[pac_pkg::IRQ_W-1:0] = ist_reg;
        pac_pkg::REG_IRQ_MASK: rdata_next[pac_pkg::IRQ_W-1:0] = imask_reg;
        default: rdata_next = '0;
      endcase
    end
    if (avs_write && !wait_reg) begin
      case (avs_address)
        pac_pkg::REG_IRQ_STAT: ist_next = ist_reg & ~(avs_writedata[pac_pkg::IRQ_W-1:0] &
          wmask[pac_pkg::IRQ_W-1:0]);
        pac_pkg::REG_IRQ_MASK: imask_next = (imask_reg & ~wmask[pac_pkg::IRQ_W-1:0]) |
          (avs_writedata[pac_pkg::IRQ_W-1:0] & wmask[pac_pkg::IRQ_W-1:0]);
        pac_pkg::REG_CTRL: begin
          sw_start_next = avs_writedata[pac_pkg::CTRL_AZ_START] & avs_byteenable[0];
          sw_reset_next = avs_writedata[pac_pkg::CTRL_AZ_RESET] & avs_byteenable[0];
        end
        default: ist_next = ist_reg;
      endcase
    end
    // set wins over clear
    ist_next = ist_next | iev;
    irq_next = |(ist_next & imask_next);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ist_reg <= '0;
      imask_reg <= '0;
      sw_start_reg <= 1'b0;
      sw_reset_reg <= 1'b0;
      rdata_reg <= '0;
      wait_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      sw_start_reg <= sw_start_next;
      sw_reset_reg <= sw_reset_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
      irq_reg <= irq_next;
    end
  end

  assign stat = '{power_on: pwr_reg, overload: ovl_reg, az_ready: ready_reg};
  assign gain_sel = gain_sel_reg;
  assign bw_sel = bw_reg;
  assign invert = inv_reg;
  assign sample_out = out_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_POWER_ON: assert property ($past(arst_n) |-> pwr_reg)
    else $error("power indication low while running");
  AST_LIVE: assert property (pins.gain_code == 3'h3 && state_reg == pac_pkg::AZ_IDLE &&
      !start_ev |=> gain_sel_reg == 6'h08)
    else $error("gain pins not honoured");
  AST_OVERLOAD: assert property (ovl_reg == $past(sig_over))
    else $error("overload pin does not follow signal");
  AST_AZ_READY_BACK: assert property ($fell(ready_reg) |-> !ready_reg [*8] ##[1:620]
      ready_reg)
    else $error("auto-zero ready timing wrong");
  AST_GAIN_MAP: assert property (state_reg == pac_pkg::AZ_IDLE && !start_ev &&
      pins.gain_code <= 3'h5 |=> gain_sel_reg == (6'h01 << $past(pins.gain_code)))
    else $error("gain code mapped wrongly");
  AST_BW_MAP: assert property (pins.bw_code == 3'b100 |=> bw_reg == pac_pkg::BW_10 ##1
      ($past(pins.bw_code) != 3'b000 || bw_reg == pac_pkg::BW_10K))
    else $error("bandwidth code mapped wrongly");
  AST_POLARITY: assert property (pins.polarity && !comp_reg |=> inv_reg &&
      out_reg == -$signed({1'b0, $past(adc_sample)}))
    else $error("polarity not applied");
  AST_AZ_DONE: assert property (state_reg == pac_pkg::AZ_CAPT && az_idx_reg == 3'h5 &&
      !rst_ev |=> comp_reg && ready_reg && state_reg == pac_pkg::AZ_IDLE)
    else $error("auto-zero did not complete");
  AST_AZ_RESET: assert property (rst_ev |=> !comp_reg && valid_reg == 6'h00 &&
      ready_reg)
    else $error("auto-zero reset did not discard offsets");
  AST_BAD_GAIN: assert property (pins.gain_code > 3'h5 |=> $stable(gain_idx_reg))
    else $error("invalid gain code applied");

  COV_AZ_DONE: cover property (done_ev);
  COV_AZ_ABORT: cover property (state_reg == pac_pkg::AZ_SETTLE && rst_ev);
  COV_BAD_CODE: cover property (bad_now && !bad_q_reg);
  COV_IRQ: cover property ($rose(irq_reg));
endmodule : pac_port
`default_nettype wire

/* File: logic/pac_pkg.sv */
// constants, types and register map of the parallel amplifier control port
// assumes a single 100 MHz clock and synchronous pin inputs
`default_nettype none
package pac_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned AZ_SETTLE_NS = 1000;
  localparam int unsigned AZ_SETTLE_CYC = (AZ_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned AZ_CNT_W = 8;
  localparam int unsigned NUM_RANGES = 6;
  localparam int unsigned ADC_W = 12;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h5;
  localparam logic [2:0] GAIN_RST_IDX = 3'h0;
  // bandwidth select, one-hot
  localparam logic [3:0] BW_10K = 4'h1;
  localparam logic [3:0] BW_1K = 4'h2;
  localparam logic [3:0] BW_100 = 4'h4;
  localparam logic [3:0] BW_10 = 4'h8;
  // register byte offsets
  localparam logic [4:0] REG_STATUS = 5'h00;
  localparam logic [4:0] REG_IRQ_STAT = 5'h04;
  localparam logic [4:0] REG_IRQ_MASK = 5'h08;
  localparam logic [4:0] REG_CTRL = 5'h0c;
  // interrupt bit positions
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_AZ_DONE = 0;
  localparam int unsigned IRQ_OVERLOAD = 1;
  localparam int unsigned IRQ_BAD_CODE = 2;
  // control bit positions
  localparam int unsigned CTRL_AZ_START = 0;
  localparam int unsigned CTRL_AZ_RESET = 1;
  // status field positions
  localparam int unsigned ST_GAIN_LSB = 0;
  localparam int unsigned ST_BW_LSB = 3;
  localparam int unsigned ST_INV = 7;
  localparam int unsigned ST_BUSY = 8;
  localparam int unsigned ST_COMP = 9;
  localparam int unsigned ST_VALID_LSB = 10;

  typedef enum logic [2:0] {
    AZ_IDLE = 3'b001,
    AZ_SETTLE = 3'b010,
    AZ_CAPT = 3'b100
  } pac_az_state_t;

  typedef struct packed {
    logic [2:0] gain_code;
    logic [2:0] bw_code;
    logic polarity;
    logic az_start;
    logic az_reset;
  } pac_pins_t;

  typedef struct packed {
    logic power_on;
    logic overload;
    logic az_ready;
  } pac_stat_t;
endpackage : pac_pkg
`default_nettype wire

/* File: logic/pac_ofs_mem.sv */
// offset store, one word per gain range, registered read
// assumes one write port and one read port on the same clock
`default_nettype none
module pac_ofs_mem (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // write side
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [pac_pkg::ADC_W-1:0] wdata,
  // read side
  input wire logic [2:0] raddr,
  output logic [pac_pkg::ADC_W-1:0] rdata
);
  logic [pac_pkg::ADC_W-1:0] mem [pac_pkg::NUM_RANGES];
  logic [pac_pkg::ADC_W-1:0] rdata_reg;

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (raddr < 3'(pac_pkg::NUM_RANGES)) begin
      rdata_reg <= mem[raddr];
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;
endmodule : pac_ofs_mem
`default_nettype wire

/* File: verif/pac_ctl_model.sv */
// external controller model driving the parallel control lines
// assumes the bench calls its tasks; lines change just after ref_clk rising edges
`default_nettype none
module pac_ctl_model (
  // clock
  input wire logic ref_clk,
  // control lines and analogue side
  output var pac_pkg::pac_pins_t pins,
  output var logic sig_over,
  output var logic [pac_pkg::ADC_W-1:0] adc_sample
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pins = '0;
    sig_over = 1'b0;
    adc_sample = '0;
  end
  task automatic set_gain(input logic [2:0] c);
    @(posedge ref_clk);
    pins.gain_code <= c;
  endtask : set_gain
  task automatic set_bw(input logic [2:0] c);
    @(posedge ref_clk);
    pins.bw_code <= c;
  endtask : set_bw
  // polarity, comparator and sample
  task automatic set_ana(input logic pol, input logic ovr, input logic [11:0] s);
    @(posedge ref_clk);
    pins.polarity <= pol;
    sig_over <= ovr;
    adc_sample <= s;
  endtask : set_ana
  task automatic stroke(input logic rst);
    @(posedge ref_clk);
    if (rst) begin
      pins.az_reset <= 1'b1;
    end else begin
      pins.az_start <= 1'b1;
    end
    repeat (3) @(posedge ref_clk);
    pins.az_start <= 1'b0;
    pins.az_reset <= 1'b0;
  endtask : stroke
endmodule : pac_ctl_model
`default_nettype wire

/* File: verif/pac_port_bench.sv */
// self-checking bench for the parallel control port
// assumes the controller model and an avalon master built from tasks here
`default_nettype none
module pac_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk;
  logic arst_n;
  pac_pkg::pac_pins_t pins;
  logic sig_over;
  logic [11:0] adc_sample;
  pac_pkg::pac_stat_t stat;
  logic [5:0] gain_sel;
  logic [3:0] bw_sel;
  logic invert;
  logic signed [12:0] sample_out;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  int n_mismatch = 0;
  int cmp_count = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  pac_port u_pac_port (.ref_clk(ref_clk), .arst_n(arst_n), .pins(pins), .sig_over(sig_over),
    .adc_sample(adc_sample), .stat(stat), .gain_sel(gain_sel), .bw_sel(bw_sel),
    .invert(invert), .sample_out(sample_out), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));

  pac_ctl_model u_pac_ctl_model (.ref_clk(ref_clk), .pins(pins), .sig_over(sig_over),
    .adc_sample(adc_sample));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    tick(20000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] q;
    logic a;
    int n;
    int e;
    arst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    tick(3);
    chk({31'h0, stat.power_on}, 32'h0);
    chk({31'h0, stat.az_ready}, 32'h1);
    tick(3);
    arst_n <= 1'b1;
    tick(2);
    chk({31'h0, stat.power_on}, 32'h1);
    for (int c = 0; c < 8; c++) begin
      u_pac_ctl_model.set_gain(3'(c));
      tick(3);
      chk({26'h0, gain_sel}, 32'h1 << (c > 5 ? 5 : c));
    end
    for (int i = 0; i < 5; i++) begin
      u_pac_ctl_model.set_bw(i < 4 ? 3'((1 << i) >> 1) : 3'h3);
      tick(3);
      chk({28'h0, bw_sel}, 32'h1 << (i > 3 ? 3 : i));
    end
    bus(1'b0, pac_pkg::REG_STATUS, 32'h0, q);
    chk(q & 32'h3ff, 32'h045);
    u_pac_ctl_model.set_gain(3'h0);
    u_pac_ctl_model.set_bw(3'h0);
    u_pac_ctl_model.set_ana(1'b1, 1'b0, 12'h123);
    tick(4);
    chk({31'h0, invert}, 32'h1);
    chk({19'h0, sample_out}, 32'h1edd);
    u_pac_ctl_model.set_ana(1'b0, 1'b1, 12'h123);
    tick(4);
    chk({31'h0, stat.overload}, 32'h1);
    chk({19'h0, sample_out}, 32'h123);
    u_pac_ctl_model.set_ana(1'b0, 1'b0, 12'h123);
    tick(3);
    chk({31'h0, stat.overload}, 32'h0);
    bus(1'b0, pac_pkg::REG_IRQ_STAT, 32'h0, q);
    chk(q, 32'h6);
    bus(1'b1, pac_pkg::REG_IRQ_MASK, 32'h0, q);
    tick(2);
    a = irq;
    bus(1'b1, pac_pkg::REG_IRQ_MASK, 32'h7, q);
    bus(1'b0, pac_pkg::REG_IRQ_MASK, 32'h0, q);
    chk(q, 32'h7);
    avs_byteenable <= 4'he;
    bus(1'b1, pac_pkg::REG_IRQ_MASK, 32'h0, q);
    avs_byteenable <= 4'hf;
    bus(1'b0, pac_pkg::REG_IRQ_MASK, 32'h0, q);
    chk(q, 32'h7);
    tick(2);
    chk({31'h0, a ^ irq}, 32'h1);
    bus(1'b1, pac_pkg::REG_IRQ_STAT, 32'h6, q);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, pac_pkg::REG_IRQ_STAT, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 5'h10, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, pac_pkg::REG_CTRL, 32'h0, q);
    chk(q, 32'h0);
    u_pac_ctl_model.stroke(1'b0);
    chk({31'h0, stat.az_ready}, 32'h0);
    tick(150);
    chk({26'h0, gain_sel}, 32'h2);
    n = 0;
    while (stat.az_ready !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    e = int'(pac_pkg::NUM_RANGES * (pac_pkg::AZ_SETTLE_CYC + 1)) - 153;
    chk({31'h0, n >= e - 5 && n <= e + 5}, 32'h1);
    tick(3);
    chk({19'h0, sample_out}, 32'h0);
    bus(1'b0, pac_pkg::REG_STATUS, 32'h0, q);
    chk(q & 32'hfe00, 32'hfe00);
    bus(1'b0, pac_pkg::REG_IRQ_STAT, 32'h0, q);
    chk(q, 32'h1);
    u_pac_ctl_model.set_ana(1'b1, 1'b0, 12'h300);
    tick(4);
    chk({19'h0, sample_out}, 32'h1e23);
    u_pac_ctl_model.stroke(1'b1);
    tick(3);
    chk({19'h0, sample_out}, 32'h1d00);
    bus(1'b0, pac_pkg::REG_STATUS, 32'h0, q);
    chk(q & 32'h200, 32'h0);
    u_pac_ctl_model.stroke(1'b0);
    tick(50);
    chk({31'h0, stat.az_ready}, 32'h0);
    u_pac_ctl_model.stroke(1'b1);
    tick(2);
    chk({31'h0, stat.az_ready}, 32'h1);
    bus(1'b1, pac_pkg::REG_CTRL, 32'h1, q);
    tick(12);
    chk({31'h0, stat.az_ready}, 32'h0);
    bus(1'b1, pac_pkg::REG_CTRL, 32'h2, q);
    tick(2);
    chk({31'h0, stat.az_ready}, 32'h1);
    tally_and_finish();
  end
endmodule : pac_port_bench
`default_nettype wire
